/* File: pkg/ppcc_map.vh */
`ifndef PPCC_MAP_VH
`define PPCC_MAP_VH
// Register byte offsets within the generator block
`define PPCC_OFF_SRC_SEL 8'h10
`define PPCC_OFF_PSC01 8'h14
`define PPCC_OFF_PSC23 8'h18
`define PPCC_OFF_PSC45 8'h1c
`define PPCC_OFF_RUN 8'h20
`define PPCC_OFF_CLR 8'h24
`define PPCC_OFF_PERIOD0 8'h30
`define PPCC_OFF_PERIOD2 8'h38
`define PPCC_OFF_PERIOD4 8'h40
`define PPCC_OFF_CNT0 8'h44
`define PPCC_OFF_CNT2 8'h48
`define PPCC_OFF_CNT4 8'h4c
// Field positions
`define PPCC_PSC_MSB 11
`define PPCC_SRC_POS0 0
`define PPCC_SRC_POS2 8
`define PPCC_SRC_POS4 16
`define PPCC_BIT_PAIR01 0
`define PPCC_BIT_PAIR23 2
`define PPCC_BIT_PAIR45 4
// Source select codes
`define PPCC_SRC_GEN_CLK 3'h0
`define PPCC_SRC_TMR0 3'h1
`define PPCC_SRC_TMR3 3'h4
// Reset values
`define PPCC_RST_WORD 32'h00000000
// AHB transfer type
`define PPCC_HTRANS_NONSEQ 2'h2
`endif

/* File: design/ppcc_top.v */
`timescale 1ns/10ps
`include "ppcc_map.vh"

// Behaviour
// - Counter clock divided by prescale plus one
// - One shared prescaler per pair, three total
// - Run bit low halts counter and prescaler
// - Run bit high lets both run
// - Writing one to clear bit zeroes counter
// - Clear bit returns to zero by itself
// - Three-bit source select per pair prescaler
// - Up-count from zero to period, restart
module ppcc_top #(
  // Prescaler and counter widths
  parameter PSC_W = 12,
  parameter CNT_W = 16
)(
  // Clock and reset
  input wire CLK_I,
  input wire NRST_I,
  // AHB-Lite slave
  input wire HSEL_I,
  input wire [7:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  // Timer overflow pulses, from other clock logic
  input wire [3:0] TMR_OVF_I,
  // Pair counters and prescaled tick
  output reg [CNT_W-1:0] CNT01_O,
  output reg [CNT_W-1:0] CNT23_O,
  output reg [CNT_W-1:0] CNT45_O,
  output reg [2:0] TICK_O
);

  // Register state
  reg [8:0] src_sel_r;
  reg [3*PSC_W-1:0] psc_r;
  reg [2:0] run_r;
  reg [2:0] clr_r;
  reg [3*CNT_W-1:0] period_r;
  reg [3*PSC_W-1:0] pdiv_r;
  // Overflow synchroniser stages
  reg [3:0] ovf_s1_r;
  reg [3:0] ovf_s2_r;
  reg [3:0] ovf_s3_r;
  // Write data-phase bookkeeping
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  // Combinational helpers
  reg [31:0] rd_nxt;
  wire [3:0] ovf_rise;
  wire [2:0] pair_evt;
  wire ahb_go;
  integer p;

  // Reserved pair bits are dropped here so they read back zero
  function [2:0] pair_bits;
    input [31:0] w;
    begin
      pair_bits = {w[`PPCC_BIT_PAIR45], w[`PPCC_BIT_PAIR23],
        w[`PPCC_BIT_PAIR01]};
    end
  endfunction

  // Spread three pair bits back to positions 0, 2 and 4
  function [31:0] pair_word;
    input [2:0] b;
    begin
      pair_word = {27'h0000000, b[2], 1'b0, b[1], 1'b0, b[0]};
    end
  endfunction

  // Source event for a pair: generator clock or a timer overflow
  function src_event;
    input [2:0] sel;
    input [3:0] rise;
    begin
      case (sel)
        `PPCC_SRC_GEN_CLK: src_event = 1'b1;
        3'h1: src_event = rise[0];
        3'h2: src_event = rise[1];
        3'h3: src_event = rise[2];
        `PPCC_SRC_TMR3: src_event = rise[3];
        default: src_event = 1'b0; // Reserved codes never tick
      endcase
    end
  endfunction

  // Up-count step: back to zero once the period value is reached.
  // Using >= rather than == means a period lowered below the count
  // wraps at the next tick instead of running through 16 bits first.
  function [CNT_W-1:0] cnt_step;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] per;
    begin
      if (cnt >= per)
        cnt_step = {CNT_W{1'b0}};
      else
        cnt_step = cnt + 1'b1;
    end
  endfunction

  // A transfer is taken only while the bus is ready; htrans bit 1 is
  // set for both NONSEQ and SEQ, and BUSY or IDLE are ignored
  assign ahb_go = HSEL_I && HREADY_I && HTRANS_I[1];

  // Overflow strobes come from another domain: two flops, then edge
  // detect on the second flop. An event costs two clocks of latency.
  // A strobe must stay high for more than one clock to be seen for
  // sure, and two strobes with less than one clock of low time
  // between them may merge into a single event.
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ovf_s1_r <= 4'h0;
      ovf_s2_r <= 4'h0;
      ovf_s3_r <= 4'h0;
    end
    else
    begin
      ovf_s1_r <= TMR_OVF_I;
      ovf_s2_r <= ovf_s1_r;
      ovf_s3_r <= ovf_s2_r;
    end
  end
  assign ovf_rise = ovf_s2_r & ~ovf_s3_r;

  // Source events per pair, masked by the run bit: a stopped pair
  // sees no events at all, so its prescaler keeps its phase
  assign pair_evt[0] = run_r[0] &&
    src_event(src_sel_r[2:0], ovf_rise);
  assign pair_evt[1] = run_r[1] &&
    src_event(src_sel_r[5:3], ovf_rise);
  assign pair_evt[2] = run_r[2] &&
    src_event(src_sel_r[8:6], ovf_rise);

  // Read mux, evaluated in the address phase
  // Counters read back live, so a value read while the pair runs is
  // already one or more ticks old by the time software uses it
  always @*
  begin
    rd_nxt = `PPCC_RST_WORD;
    case (HADDR_I)
      `PPCC_OFF_SRC_SEL: rd_nxt = {13'h0000, src_sel_r[8:6], 5'h00,
        src_sel_r[5:3], 5'h00, src_sel_r[2:0]};
      `PPCC_OFF_PSC01: rd_nxt = {20'h00000, psc_r[PSC_W-1:0]};
      `PPCC_OFF_PSC23: rd_nxt = {20'h00000, psc_r[2*PSC_W-1:PSC_W]};
      `PPCC_OFF_PSC45: rd_nxt = {20'h00000, psc_r[3*PSC_W-1:2*PSC_W]};
      `PPCC_OFF_RUN: rd_nxt = pair_word(run_r);
      `PPCC_OFF_CLR: rd_nxt = pair_word(clr_r);
      `PPCC_OFF_PERIOD0: rd_nxt = {16'h0000, period_r[CNT_W-1:0]};
      `PPCC_OFF_PERIOD2: rd_nxt = {16'h0000, period_r[2*CNT_W-1:CNT_W]};
      `PPCC_OFF_PERIOD4: rd_nxt = {16'h0000,
        period_r[3*CNT_W-1:2*CNT_W]};
      `PPCC_OFF_CNT0: rd_nxt = {16'h0000, CNT01_O};
      `PPCC_OFF_CNT2: rd_nxt = {16'h0000, CNT23_O};
      `PPCC_OFF_CNT4: rd_nxt = {16'h0000, CNT45_O};
      default: rd_nxt = `PPCC_RST_WORD;
    endcase
  end

  // Bus slave: zero wait states, always OKAY; write lands in data phase
  // The write address is parked for one cycle because the write data
  // only arrives in the data phase. Reads answer from the address
  // phase, so a read issued right behind a write to the same register
  // still sees the old value; software leaves one idle cycle there.
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      HRDATA_O <= `PPCC_RST_WORD;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= ahb_go && HWRITE_I;
      if (ahb_go)
        wr_addr_r <= HADDR_I;
      if (ahb_go && !HWRITE_I)
        HRDATA_O <= rd_nxt;
    end
  end

  // Register writes; clear bits self-clear on the same edge that they act
  // A clear bit lives for one clock only, so software never has to
  // write it back, and a read catches it set only in that cycle
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      src_sel_r <= 9'h000;
      psc_r <= {3*PSC_W{1'b0}};
      run_r <= 3'h0;
      clr_r <= 3'h0;
      period_r <= {3*CNT_W{1'b0}};
    end
    else
    begin
      clr_r <= 3'h0;
      if (wr_pend_r)
      begin
        case (wr_addr_r)
          `PPCC_OFF_SRC_SEL: src_sel_r <= {HWDATA_I[`PPCC_SRC_POS4+2:
            `PPCC_SRC_POS4], HWDATA_I[`PPCC_SRC_POS2+2:`PPCC_SRC_POS2],
            HWDATA_I[`PPCC_SRC_POS0+2:`PPCC_SRC_POS0]};
          `PPCC_OFF_PSC01: psc_r[PSC_W-1:0] <=
            HWDATA_I[`PPCC_PSC_MSB:0];
          `PPCC_OFF_PSC23: psc_r[2*PSC_W-1:PSC_W] <=
            HWDATA_I[`PPCC_PSC_MSB:0];
          `PPCC_OFF_PSC45: psc_r[3*PSC_W-1:2*PSC_W] <=
            HWDATA_I[`PPCC_PSC_MSB:0];
          `PPCC_OFF_RUN: run_r <= pair_bits(HWDATA_I);
          `PPCC_OFF_CLR: clr_r <= pair_bits(HWDATA_I);
          `PPCC_OFF_PERIOD0: period_r[CNT_W-1:0] <= HWDATA_I[15:0];
          `PPCC_OFF_PERIOD2: period_r[2*CNT_W-1:CNT_W] <= HWDATA_I[15:0];
          `PPCC_OFF_PERIOD4: period_r[3*CNT_W-1:2*CNT_W] <=
            HWDATA_I[15:0];
          default: ;
        endcase
      end
    end
  end

  // Three independent prescalers, one per pair, each a tick enable
  // The phase counter steps on each source event and ticks when it
  // reaches the prescale value. Lowering the prescale below the
  // current phase ticks at the next event instead of waiting for a
  // full wrap of the phase counter.
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pdiv_r <= {3*PSC_W{1'b0}};
      TICK_O <= 3'h0;
    end
    else
    begin
      for (p = 0; p < 3; p = p + 1)
      begin
        TICK_O[p] <= 1'b0;
        if (pair_evt[p])
        begin
          // Count source events, tick every prescale+1 of them
          if (pdiv_r[PSC_W*p +: PSC_W] >= psc_r[PSC_W*p +: PSC_W])
          begin
            pdiv_r[PSC_W*p +: PSC_W] <= {PSC_W{1'b0}};
            TICK_O[p] <= 1'b1;
          end
          else
            pdiv_r[PSC_W*p +: PSC_W] <=
              pdiv_r[PSC_W*p +: PSC_W] + 1'b1;
        end
        // Stopped prescaler holds its phase
      end
    end
  end

  // Pair counters; clear wins over a tick in the same cycle
  // A tick is only raised while the pair runs, so the counter follows
  // the tick alone. A tick in flight when software stops the pair
  // still lands: the count settles one clock after the stop.
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      CNT01_O <= {CNT_W{1'b0}};
      CNT23_O <= {CNT_W{1'b0}};
      CNT45_O <= {CNT_W{1'b0}};
    end
    else
    begin
      // Pair 01
      if (clr_r[0])
        CNT01_O <= {CNT_W{1'b0}};
      else if (TICK_O[0])
        CNT01_O <= cnt_step(CNT01_O, period_r[CNT_W-1:0]);
      // Pair 23
      if (clr_r[1])
        CNT23_O <= {CNT_W{1'b0}};
      else if (TICK_O[1])
        CNT23_O <= cnt_step(CNT23_O, period_r[2*CNT_W-1:CNT_W]);
      // Pair 45
      if (clr_r[2])
        CNT45_O <= {CNT_W{1'b0}};
      else if (TICK_O[2])
        CNT45_O <= cnt_step(CNT45_O, period_r[3*CNT_W-1:2*CNT_W]);
    end
  end

endmodule

/* File: verif/ppcc_props.sv */
`timescale 1ns/10ps
module ppcc_props #(
  parameter CNT_W = 16
)(
  // Clock and reset
  input wire CLK_I,
  input wire NRST_I,
  // Bus answer
  input wire HREADYOUT_O,
  input wire HRESP_O,
  // Counters and ticks
  input wire [CNT_W-1:0] CNT01_O,
  input wire [CNT_W-1:0] CNT23_O,
  input wire [CNT_W-1:0] CNT45_O,
  input wire [2:0] TICK_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // Zero counts as legal after a tick: wrap and clear both give it
  a_resp_okay: assert property (HRESP_O == 1'b0) else $error("resp bad");
  a_ready_high: assert property (HREADYOUT_O) else $error("wait state");
  a_step_p01: assert property (TICK_O[0] |=> CNT01_O == 16'h0 ||
    CNT01_O == $past(CNT01_O) + 16'h1) else $error("p01 step");
  a_step_p23: assert property (TICK_O[1] |=> CNT23_O == 16'h0 ||
    CNT23_O == $past(CNT23_O) + 16'h1) else $error("p23 step");
  a_step_p45: assert property (TICK_O[2] |=> CNT45_O == 16'h0 ||
    CNT45_O == $past(CNT45_O) + 16'h1) else $error("p45 step");
  a_hold_p01: assert property (!TICK_O[0] |=> $stable(CNT01_O) ||
    CNT01_O == 16'h0) else $error("p01 moved");
  a_hold_p23: assert property (!TICK_O[1] |=> $stable(CNT23_O) ||
    CNT23_O == 16'h0) else $error("p23 moved");
  a_hold_p45: assert property (!TICK_O[2] |=> $stable(CNT45_O) ||
    CNT45_O == 16'h0) else $error("p45 moved");
endmodule

/* File: verif/ppcc_top_tb.sv */
`timescale 1ns/10ps
`include "ppcc_map.vh"
module ppcc_top_tb;
  logic CLK_I = 0, NRST_I = 0, HSEL_I = 0, HWRITE_I = 0;
  logic [7:0] HADDR_I = 0;
  logic [1:0] HTRANS_I = 0;
  logic [31:0] HWDATA_I = 0, rd;
  logic [3:0] TMR_OVF_I = 0;
  logic [15:0] mx, sv;
  wire [31:0] HRDATA_O;
  wire HREADYOUT_O, HRESP_O;
  wire [15:0] CNT01_O, CNT23_O, CNT45_O;
  wire [2:0] TICK_O;
  int miscompares = 0, check_count = 0, tk[3];
  // Address, write data, read-back expected
  logic [71:0] rows [7] = '{{8'h14, 32'hffffffff, 32'h00000fff},
    {8'h18, 32'hffffffff, 32'h00000fff}, {8'h1c, 32'hffffffff, 32'hfff},
    {8'h10, 32'hffffffff, 32'h00070707}, {8'h20, 32'hffffffea, 32'h0},
    {8'h24, 32'hffffffea, 32'h0}, {8'h28, 32'hffffffff, 32'h0}};
  ppcc_top i_ppcc_top (.CLK_I(CLK_I), .NRST_I(NRST_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HSIZE_I(3'h2), .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .TMR_OVF_I(TMR_OVF_I), .CNT01_O(CNT01_O), .CNT23_O(CNT23_O),
    .CNT45_O(CNT45_O), .TICK_O(TICK_O));
  initial forever #2 CLK_I = ~CLK_I;
  task conclude;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Bounded wait so a stuck slave ends the run instead of hanging it
  task rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge CLK_I);
      n++;
    end
    while (HREADYOUT_O !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      conclude;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL_I <= 1;
    HTRANS_I <= `PPCC_HTRANS_NONSEQ;
    HADDR_I <= a;
    HWRITE_I <= w;
    rdy;
    HSEL_I <= 0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    rdy;
    rd = HRDATA_O;
  endtask
  // Ticks sampled on the falling edge, away from register updates
  task ticks(input int n);
    tk = '{0, 0, 0};
    mx = 0;
    repeat (n)
    begin
      @(negedge CLK_I);
      for (int k = 0; k < 3; k++)
        tk[k] += (TICK_O[k] === 1'b1);
      if (CNT45_O > mx)
        mx = CNT45_O;
    end
    @(posedge CLK_I);
  endtask
  initial
  begin
    repeat (3) @(posedge CLK_I);
    NRST_I <= 1;
    @(posedge CLK_I);
    foreach (rows[i])
    begin
      bus(0, rows[i][71:64], 0);
      chk(rd, `PPCC_RST_WORD);
      bus(1, rows[i][71:64], rows[i][63:32]);
      bus(0, rows[i][71:64], 0);
      chk(rd, rows[i][31:0]);
    end
    $display("test done: registers");
    bus(1, `PPCC_OFF_RUN, 32'h15);
    bus(1, `PPCC_OFF_PSC01, 0);
    ticks(20);
    chk(tk[0] + tk[1] + tk[2], 0);
    bus(1, `PPCC_OFF_SRC_SEL, 0);
    bus(1, `PPCC_OFF_PSC01, 2);
    bus(1, `PPCC_OFF_PSC23, 4);
    bus(1, `PPCC_OFF_PSC45, 0);
    bus(1, `PPCC_OFF_PERIOD0, 32'hffff);
    bus(1, `PPCC_OFF_PERIOD2, 32'hffff);
    bus(1, `PPCC_OFF_PERIOD4, 3);
    ticks(30);
    chk(tk[0], 10);
    chk(tk[1], 6);
    chk(tk[2], 30);
    chk(mx, 3);
    $display("test done: division");
    bus(1, `PPCC_OFF_RUN, 0);
    ticks(2);
    sv = CNT01_O;
    ticks(10);
    chk(CNT01_O, sv);
    chk(tk[0] + tk[1] + tk[2], 0);
    bus(1, `PPCC_OFF_CLR, 32'h15);
    ticks(2);
    chk({CNT01_O, CNT23_O}, 0);
    chk(CNT45_O, 0);
    bus(0, `PPCC_OFF_CLR, 0);
    chk(rd, 0);
    $display("test done: stop and clear");
    bus(1, `PPCC_OFF_SRC_SEL, 32'h00040401);
    bus(1, `PPCC_OFF_PSC01, 0);
    bus(1, `PPCC_OFF_PSC23, 0);
    bus(1, `PPCC_OFF_RUN, 32'h15);
    fork
      ticks(30);
      repeat (5)
      begin
        TMR_OVF_I <= 4'h9;
        repeat (2) @(posedge CLK_I);
        TMR_OVF_I <= 4'h0;
        repeat (2) @(posedge CLK_I);
      end
    join
    chk(tk[0], 5);
    chk(tk[1], 5);
    chk(tk[2], 5);
    $display("test done: timer sources");
    // Reset in mid-run: all back to idle, nothing ticks afterwards
    NRST_I <= 0;
    @(posedge CLK_I);
    chk(CNT45_O, 0);
    chk(HRDATA_O, 0);
    NRST_I <= 1;
    @(posedge CLK_I);
    bus(0, `PPCC_OFF_RUN, 0);
    chk(rd, 0);
    bus(0, `PPCC_OFF_PSC45, 0);
    chk(rd, 0);
    ticks(10);
    chk(tk[0] + tk[1] + tk[2], 0);
    $display("test done: reset");
    conclude;
  end
endmodule
bind ppcc_top ppcc_props #(.CNT_W(CNT_W)) i_ppcc_props (.CLK_I(CLK_I),
  .NRST_I(NRST_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .CNT01_O(CNT01_O), .CNT23_O(CNT23_O), .CNT45_O(CNT45_O),
  .TICK_O(TICK_O));
